// >>> rtl/scm_defs.svh
// constants shared by both ends of the serial code memory readout link
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH
`define SCM_CMD_EXEC      4'h0
`define SCM_CMD_REGISTER_OUTPUT_COMMAND    4'h1
`define SCM_FRAME_BITS    28
`define SCM_CMD_LAST      5'h03
`define SCM_OUT_FIRST     5'h0B
`define SCM_FRAME_LAST    5'h1B
`define SCM_OUT_BITS      16
`define SCM_OP_NOP        24'h000000
`define SCM_OP_GOTO_RESET 24'h040200
`define SCM_OP_GOTO       8'h04
`define SCM_OP_MOV_LIT    4'h2
`define SCM_OP_MOV_W0_LIT 24'h200000
`define SCM_OP_MOV_W6_LIT 24'h200006
`define SCM_OP_W0_TO_PAGE 24'h880190
`define SCM_OP_VISI_TO_W7 24'h207847
`define SCM_OP_TRL_NOINC  24'hBA0B96
`define SCM_OP_TRH_POST   24'hBADBB6
`define SCM_OP_TRH_PRE    24'hBAD3D6
`define SCM_OP_TRL_POST   24'hBA0BB6
`define SCM_REG_W0        4'h0
`define SCM_REG_W6        4'h6
`define SCM_REG_W7        4'h7
`define SCM_VISI_ADDR     16'h0784
`define SCM_PC_STEP       24'h000002
`define SCM_STEP_LOOP     5'h08
`define SCM_STEP_LOOP_END 5'h19
`define SCM_STEP_LAST     5'h1B
`define SCM_CLK_PERIOD_NS 5
`define SCM_PGC_PERIOD_NS 80
`define SCM_PGC_HALF_CYC  (`SCM_PGC_PERIOD_NS / (2 * `SCM_CLK_PERIOD_NS))
`endif

// >>> rtl/scm_pkg.sv
// types shared by the serial code memory readout ends
package scm_pkg;
  typedef logic [3:0]  scm_cmd_t;
  typedef logic [23:0] scm_word_t;
  typedef enum logic {SCM_H_IDLE, SCM_H_RUN} scm_host_st_t;
endpackage

// >>> rtl/scm_link_if.sv
// two-pin programming link between programmer and device
`timescale 1ns/100ps
interface scm_link_if;
  logic pgc;
  logic prog_pgd_out;
  logic prog_pgd_oe;
  logic dev_pgd_out;
  logic dev_pgd_oe;
  logic pgd;
  // pull-up keeps the released line high
  assign pgd = prog_pgd_oe ? prog_pgd_out : (dev_pgd_oe ? dev_pgd_out : 1'b1);
  modport prog (output pgc, output prog_pgd_out, output prog_pgd_oe, input pgd);
  modport dev  (input pgc, input pgd, output dev_pgd_out, output dev_pgd_oe);
endinterface

// >>> rtl/scm_device.sv
// device end: link shifter on the programming clock, table-read core on clk
`timescale 1ns/100ps
`include "scm_defs.svh"
module scm_device #(
  parameter int MEM_AW = 8
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                mem_wr_en,
  input  wire logic [MEM_AW-1:0]   mem_wr_addr,
  input  wire scm_pkg::scm_word_t  mem_wr_data,
  output logic      [23:0]         core_pc,
  output logic      [15:0]         visi_out,
  output logic                     bad_instr,
  scm_link_if.dev                  link
);
  logic [27:0]         lsh_reg;
  logic [4:0]          cnt_reg;
  scm_pkg::scm_cmd_t   cmd_reg;
  scm_pkg::scm_word_t  instr_reg;
  logic                req_reg;
  logic                ack_s1_reg, ack_s2_reg, ack_seen_reg;
  logic [15:0]         snap_reg, ob_reg;
  logic                req_s1_reg, req_s2_reg, req_seen_reg, ack_reg;
  logic [15:0]         w0_reg, w6_reg, w7_reg;
  logic [7:0]          page_reg;
  scm_pkg::scm_word_t  mem [0:(1<<MEM_AW)-1];
  logic [23:0]         ea;
  scm_pkg::scm_word_t  word;
  logic [7:0]          hi_byte;
  logic                hit;
  logic                exec;

  // link side: every bit arrives lsb first on the rising programming clock
  always_ff @(posedge link.pgc or negedge resetn) begin
    if (!resetn) begin
      cnt_reg   <= 5'h00;
      lsh_reg   <= 28'h0000000;
      cmd_reg   <= 4'h0;
      instr_reg <= 24'h000000;
      req_reg   <= 1'b0;
    end else begin
      lsh_reg <= {link.pgd, lsh_reg[27:1]};
      cnt_reg <= (cnt_reg == `SCM_FRAME_LAST) ? 5'h00 : cnt_reg + 5'h01;
      if (cnt_reg == `SCM_CMD_LAST)
        cmd_reg <= {link.pgd, lsh_reg[27:25]};
      // payload held stable for the core until the next frame ends
      if (cnt_reg == `SCM_FRAME_LAST && cmd_reg == `SCM_CMD_EXEC) begin
        instr_reg <= {link.pgd, lsh_reg[27:5]};
        req_reg   <= ~req_reg;
      end
    end
  end

  // output register copy taken only once the core has acknowledged
  always_ff @(posedge link.pgc or negedge resetn) begin
    if (!resetn) begin
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      snap_reg     <= 16'h0000;
    end else begin
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
      if (ack_s2_reg != ack_seen_reg) begin
        ack_seen_reg <= ack_s2_reg;
        snap_reg     <= visi_out;
      end
    end
  end

  // register output: 8 idle clocks, then 16 bits lsb first
  always_ff @(posedge link.pgc or negedge resetn) begin
    if (!resetn) begin
      link.dev_pgd_oe  <= 1'b0;
      link.dev_pgd_out <= 1'b0;
      ob_reg           <= 16'h0000;
    end else if (cmd_reg == `SCM_CMD_REGISTER_OUTPUT_COMMAND && cnt_reg == `SCM_OUT_FIRST) begin
      link.dev_pgd_oe  <= 1'b1;
      link.dev_pgd_out <= snap_reg[0];
      ob_reg           <= {1'b0, snap_reg[15:1]};
    end else if (cnt_reg == `SCM_FRAME_LAST) begin
      link.dev_pgd_oe <= 1'b0;
    end else if (link.dev_pgd_oe) begin
      link.dev_pgd_out <= ob_reg[0];
      ob_reg           <= {1'b0, ob_reg[15:1]};
    end
  end

  // core side: toggle handshake, first stage only feeds the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_reg      <= 1'b0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      if (exec) begin
        req_seen_reg <= req_s2_reg;
        ack_reg      <= ~ack_reg;
      end
    end
  end

  assign exec = req_s2_reg != req_seen_reg;

  always_ff @(posedge clk) begin
    if (mem_wr_en)
      mem[mem_wr_addr] <= mem_wr_data;
  end

  // pre-increment form reads the byte after the pointer
  assign ea      = {page_reg, (instr_reg == `SCM_OP_TRH_PRE) ? w6_reg + 16'h0001 : w6_reg};
  assign word    = mem[ea[MEM_AW:1]];
  assign hi_byte = ea[0] ? 8'h00 : word[23:16];
  assign hit     = {w7_reg[15:1], 1'b0} == `SCM_VISI_ADDR;

  // lanes follow the instruction so repeated passes keep landing in the
  // output word; the write pointer itself is never advanced
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_pc   <= 24'h000000;
      w0_reg    <= 16'h0000;
      w6_reg    <= 16'h0000;
      w7_reg    <= 16'h0000;
      page_reg  <= 8'h00;
      visi_out  <= 16'h0000;
      bad_instr <= 1'b0;
    end else if (exec) begin
      if (instr_reg[23:16] == `SCM_OP_GOTO)
        core_pc <= {8'h00, instr_reg[15:0]};
      else
        core_pc <= core_pc + `SCM_PC_STEP;
      case (instr_reg)
        `SCM_OP_NOP: ;
        `SCM_OP_W0_TO_PAGE: page_reg <= w0_reg[7:0];
        `SCM_OP_TRL_NOINC: begin
          if (hit) visi_out <= word[15:0];
        end
        `SCM_OP_TRH_POST: begin
          if (hit) visi_out[7:0] <= hi_byte;
          w6_reg <= w6_reg + 16'h0001;
        end
        `SCM_OP_TRH_PRE: begin
          if (hit) visi_out[15:8] <= hi_byte;
          w6_reg <= w6_reg + 16'h0001;
        end
        `SCM_OP_TRL_POST: begin
          if (hit) visi_out <= word[15:0];
          w6_reg <= w6_reg + 16'h0002;
        end
        default: begin
          if (instr_reg[23:20] == `SCM_OP_MOV_LIT) begin
            case (instr_reg[3:0])
              `SCM_REG_W0: w0_reg <= instr_reg[19:4];
              `SCM_REG_W6: w6_reg <= instr_reg[19:4];
              `SCM_REG_W7: w7_reg <= instr_reg[19:4];
              default: ;
            endcase
          end else if (instr_reg[23:16] != `SCM_OP_GOTO) begin
            bad_instr <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// >>> rtl/scm_programmer.sv
// programmer end: runs the whole code memory readout sequence over the link
`timescale 1ns/100ps
`include "scm_defs.svh"
// Operation
// - readout is device-executed table reads plus output
// - address top byte to page, low to pointer
// - nop, jump to 0x200, nop leave vector
// - upper byte via working register zero first
// - write pointer at output register, then nop
// - each pass fetches two instruction words
// - packed layout: two words in three transfers
// - fixed pass order, two nops per read
// - output command 0001, nop afterwards
// - repeat passes, pointer advancing by itself
// - all frames shifted lsb first on pins
// - output register sits at data address 784h
module scm_programmer #(
  parameter int HALF = `SCM_PGC_HALF_CYC
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic [23:0]   req_addr,
  input  wire logic [15:0]   req_passes,
  output logic               rsp_valid,
  output logic [15:0]        rsp_data,
  output logic               done,
  scm_link_if.prog           link
);
  scm_pkg::scm_host_st_t st_reg;
  logic [4:0]            step_reg;
  logic [15:0]           passes_reg;
  logic [23:0]           addr_reg;
  logic                  pgd_s1_reg, pgd_s2_reg;
  logic                  active_reg;
  logic                  is_out_reg;
  logic [7:0]            div_reg;
  logic [4:0]            bit_reg;
  logic [27:0]           sh_reg;
  logic [15:0]           rd_reg;
  logic [27:0]           frame;
  logic                  tick;
  logic                  frame_end;
  logic                  frame_start;
  logic                  pgc_up;
  logic                  pgc_down;
  logic                  run_last;

  // one frame per step: {payload, command}, shifted lsb first
  function automatic logic [27:0] step_frame(input logic [4:0] s, input logic [23:0] a);
    scm_pkg::scm_cmd_t  c;
    scm_pkg::scm_word_t p;
    c = `SCM_CMD_EXEC;
    p = `SCM_OP_NOP;
    case (s)
      5'h01, 5'h1A: p = `SCM_OP_GOTO_RESET;
      5'h03: p = `SCM_OP_MOV_W0_LIT | {12'h000, a[23:16], 4'h0};
      5'h04: p = `SCM_OP_W0_TO_PAGE;
      5'h05: p = `SCM_OP_MOV_W6_LIT | {4'h0, a[15:0], 4'h0};
      5'h06: p = `SCM_OP_VISI_TO_W7;
      5'h08: p = `SCM_OP_TRL_NOINC;
      5'h0D: p = `SCM_OP_TRH_POST;
      5'h10: p = `SCM_OP_TRH_PRE;
      5'h15: p = `SCM_OP_TRL_POST;
      5'h0B, 5'h13, 5'h18: c = `SCM_CMD_REGISTER_OUTPUT_COMMAND;
      default: ;
    endcase
    return {p, c};
  endfunction

  assign frame       = step_frame(step_reg, addr_reg);
  assign tick        = div_reg == 8'(HALF - 1);
  assign frame_start = !active_reg && st_reg == scm_pkg::SCM_H_RUN;
  assign pgc_up      = active_reg && tick && !link.pgc;
  assign pgc_down    = active_reg && tick && link.pgc;
  assign frame_end   = pgc_down && bit_reg == `SCM_FRAME_LAST;
  assign run_last    = frame_end && step_reg == `SCM_STEP_LAST;

  // returned data comes from the far side, so it is synchronised first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pgd_s1_reg <= 1'b0;
      pgd_s2_reg <= 1'b0;
    end else begin
      pgd_s1_reg <= link.pgd;
      pgd_s2_reg <= pgd_s1_reg;
    end
  end

  // sequencer: steps 0..7 set up, 8..25 one pass, 26..27 wind up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg     <= scm_pkg::SCM_H_IDLE;
      step_reg   <= 5'h00;
      passes_reg <= 16'h0000;
      addr_reg   <= 24'h000000;
    end else begin
      unique case (st_reg)
        scm_pkg::SCM_H_IDLE: begin
          if (req_valid) begin
            addr_reg   <= req_addr;
            passes_reg <= (req_passes == 16'h0000) ? 16'h0001 : req_passes;
            step_reg   <= 5'h00;
            st_reg     <= scm_pkg::SCM_H_RUN;
          end
        end
        scm_pkg::SCM_H_RUN: begin
          if (frame_end) begin
            if (step_reg == `SCM_STEP_LOOP_END && passes_reg > 16'h0001) begin
              step_reg   <= `SCM_STEP_LOOP;
              passes_reg <= passes_reg - 16'h0001;
            end else if (run_last) begin
              st_reg <= scm_pkg::SCM_H_IDLE;
            end else begin
              step_reg <= step_reg + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // requester handshake: busy from acceptance until the closing frame ends
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b1;
      done      <= 1'b0;
    end else begin
      done <= run_last;
      if (st_reg == scm_pkg::SCM_H_IDLE && req_valid)
        req_ready <= 1'b0;
      else if (run_last)
        req_ready <= 1'b1;
    end
  end

  // frame position: one frame in flight, the next starts one clk after
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_reg <= 1'b0;
      is_out_reg <= 1'b0;
      bit_reg    <= 5'h00;
      sh_reg     <= 28'h0000000;
    end else if (frame_start) begin
      active_reg <= 1'b1;
      is_out_reg <= frame[3:0] == `SCM_CMD_REGISTER_OUTPUT_COMMAND;
      bit_reg    <= 5'h00;
      sh_reg     <= frame;
    end else if (frame_end) begin
      active_reg <= 1'b0;
    end else if (pgc_down) begin
      bit_reg <= bit_reg + 5'h01;
      sh_reg  <= {1'b0, sh_reg[27:1]};
    end
  end

  // link clock is divided from clk and stands low between frames
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 8'h00;
    end else if (frame_start) begin
      div_reg <= 8'h00;
    end else if (active_reg) begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.pgc <= 1'b0;
    end else if (pgc_up) begin
      link.pgc <= 1'b1;
    end else if (pgc_down) begin
      link.pgc <= 1'b0;
    end
  end

  // data changes only while the clock is low, so the far end never races it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.prog_pgd_out <= 1'b0;
      link.prog_pgd_oe  <= 1'b0;
    end else if (frame_start) begin
      link.prog_pgd_out <= frame[0];
      link.prog_pgd_oe  <= 1'b1;
    end else if (frame_end) begin
      link.prog_pgd_oe <= 1'b0;
    end else if (pgc_down) begin
      link.prog_pgd_out <= sh_reg[1];
      // release the line after the command of an output frame
      link.prog_pgd_oe  <= !is_out_reg || bit_reg < `SCM_CMD_LAST;
    end
  end

  // device answer is stable a full period before each rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_reg <= 16'h0000;
    end else if (pgc_up && is_out_reg && bit_reg > `SCM_OUT_FIRST) begin
      rd_reg <= {pgd_s2_reg, rd_reg[15:1]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= frame_end && is_out_reg;
      if (frame_end)
        rsp_data <= rd_reg;
    end
  end
endmodule

// >>> sim/scm_link_checker.sv
// concurrent checks on the two-pin programming link
`timescale 1ns/100ps
module scm_link_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pgc,
  input wire logic prog_pgd_out,
  input wire logic prog_pgd_oe,
  input wire logic dev_pgd_out,
  input wire logic dev_pgd_oe,
  input wire logic pgd
);
  logic       pgc_q;
  logic       pgc_rise;
  logic [4:0] rcnt;
  logic [4:0] rc_now;
  logic [3:0] cmd_reg;
  logic [8:0] drv_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // position in frame counted as the rise is seen, not one clock late
  assign pgc_rise = pgc && !pgc_q;
  assign rc_now   = !pgc_rise ? rcnt : (rcnt == 5'h1C) ? 5'h01 : rcnt + 5'h01;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pgc_q <= 1'b0;
      rcnt  <= 5'h00;
    end else begin
      pgc_q <= pgc;
      rcnt  <= rc_now;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= 4'h0;
    end else if (pgc_rise && rc_now <= 5'h04) begin
      cmd_reg <= {pgd, cmd_reg[3:1]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drv_cnt <= 9'h000;
    end else begin
      drv_cnt <= dev_pgd_oe ? drv_cnt + 9'h001 : 9'h000;
    end
  end

  sequence s_high8;
    pgc [*8] ##1 !pgc;
  endsequence
  sequence s_low8;
    !pgc [*8];
  endsequence

  a_no_contention: assert property (!(prog_pgd_oe && dev_pgd_oe))
    else $error("both ends drive the data line");
  a_pgc_high_len: assert property ($rose(pgc) |-> s_high8)
    else $error("link clock high phase not eight clocks");
  a_pgc_low_len: assert property ($fell(pgc) |-> s_low8)
    else $error("link clock low phase too short");
  a_prog_on_fall: assert property ($changed(prog_pgd_out) && prog_pgd_oe |-> !pgc)
    else $error("programmer data moved while clock high");
  a_dev_on_rise: assert property ($changed(dev_pgd_oe) || $changed(dev_pgd_out) |-> pgc_rise)
    else $error("device data moved away from a clock rise");
  a_dev_register_output_command_only: assert property (dev_pgd_oe |-> cmd_reg == 4'h1 && rc_now >= 5'h0C)
    else $error("device drives outside the output window");
  a_prog_released: assert property (cmd_reg == 4'h1 && rc_now >= 5'h05 && rc_now <= 5'h1B
    |-> !prog_pgd_oe)
    else $error("programmer still drives during output frame");
  a_dev_drive_len: assert property ($fell(dev_pgd_oe) |-> drv_cnt == 9'h100)
    else $error("device output not sixteen bit periods");
endmodule

// >>> sim/serial_code_memory_readout_tb_top.sv
// self-checking bench: programmer and device joined over the link
`timescale 1ns/100ps
module serial_code_memory_readout_tb_top;
  logic               clk, resetn, mem_wr_en, req_valid, req_ready;
  logic               rsp_valid, done, bad_instr;
  logic [7:0]         mem_wr_addr;
  scm_pkg::scm_word_t mem_wr_data;
  logic [23:0]        req_addr, core_pc;
  logic [15:0]        req_passes, rsp_data, visi_out;
  logic [27:0]        sh;
  int                 nb, errors, samples_checked;
  scm_pkg::scm_word_t mem [256];
  logic [27:0]        frm_q [$], exp_q [$], msk_q [$];
  logic [15:0]        got_q [$], exw_q [$];

  scm_link_if link ();
  scm_programmer u_scm_programmer (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_passes(req_passes),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done), .link(link));
  scm_device u_scm_device (.clk(clk), .resetn(resetn), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .core_pc(core_pc),
    .visi_out(visi_out), .bad_instr(bad_instr), .link(link));
  scm_link_checker chk_link (.clk(clk), .resetn(resetn), .pgc(link.pgc),
    .prog_pgd_out(link.prog_pgd_out), .prog_pgd_oe(link.prog_pgd_oe),
    .dev_pgd_out(link.dev_pgd_out), .dev_pgd_oe(link.dev_pgd_oe), .pgd(link.pgd));

  always #2.5 clk = ~clk;

  // frames counted from reset since the clock gap between frames is only one cycle
  always @(posedge link.pgc or negedge resetn) begin
    if (!resetn) begin
      nb = 0;
    end else begin
      sh = {link.pgd, sh[27:1]};
      nb = nb + 1;
      if (nb == 28) begin
        frm_q.push_back(sh);
        nb = 0;
      end
    end
  end

  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      got_q.push_back(rsp_data);
    end
  end

  task automatic cmp(input logic [27:0] got, input logic [27:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ex(input logic [23:0] p, input logic [3:0] c = 4'h0,
                    input logic [27:0] m = 28'hFFFFFFF);
    exp_q.push_back({p, c});
    msk_q.push_back(m);
  endtask

  task automatic nop2;
    ex(24'h000000);
    ex(24'h000000);
  endtask

  // idle bits before the device turns the line round are not compared
  task automatic rg(input logic [15:0] w);
    ex({w, 8'h00}, 4'h1, 28'hFFFF00F);
    exw_q.push_back(w);
    ex(24'h000000);
  endtask

  task automatic build(input logic [23:0] a, input int np);
    logic [23:0]        b;
    scm_pkg::scm_word_t w0, w1;
    ex(24'h000000);
    ex(24'h040200);
    ex(24'h000000);
    ex({12'h200, a[23:16], 4'h0});
    ex(24'h880190);
    ex({4'h2, a[15:0], 4'h6});
    ex(24'h207847);
    ex(24'h000000);
    for (int p = 0; p < np; p++) begin
      b = a + 24'(4 * p);
      w0 = mem[b[8:1]];
      b = b + 24'h000002;
      w1 = mem[b[8:1]];
      ex(24'hBA0B96);
      nop2();
      rg(w0[15:0]);
      ex(24'hBADBB6);
      nop2();
      ex(24'hBAD3D6);
      nop2();
      rg({w1[23:16], w0[23:16]});
      ex(24'hBA0BB6);
      nop2();
      rg(w1[15:0]);
    end
    ex(24'h040200);
    ex(24'h000000);
  endtask

  task automatic readout(input logic [23:0] a, input logic [15:0] n, input bit poke);
    int k;
    exp_q.delete();
    msk_q.delete();
    exw_q.delete();
    frm_q.delete();
    got_q.delete();
    build(a, (n == 16'h0000) ? 1 : int'(n));
    req_addr = a;
    req_passes = n;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    cmp(28'(req_ready), 28'h0, "ready while busy");
    if (poke) begin
      // a second request mid-run must change nothing
      repeat (3000) @(negedge clk);
      req_addr = a ^ 24'h000040;
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    cmp(28'(done), 28'h1, "done pulse");
    @(negedge clk);
    cmp(28'(req_ready), 28'h1, "ready after done");
    cmp(28'(frm_q.size()), 28'(exp_q.size()), "frame count");
    foreach (exp_q[i]) cmp(frm_q[i] & msk_q[i], exp_q[i] & msk_q[i], "frame");
    cmp(28'(got_q.size()), 28'(exw_q.size()), "word count");
    foreach (exw_q[i]) cmp(28'(got_q[i]), 28'(exw_q[i]), "word");
    cmp(28'(core_pc), 28'h0000202, "program counter");
    cmp(28'(visi_out), 28'(exw_q[$]), "output register");
    cmp(28'(bad_instr), 28'h0, "bad instruction flag");
  endtask

  task automatic preload;
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'(i) ^ 8'hA5, 8'(i) + 8'h3C, 8'(i)};
      mem_wr_en = 1'b1;
      mem_wr_addr = 8'(i);
      mem_wr_data = mem[i];
      @(negedge clk);
    end
    mem_wr_en = 1'b0;
  endtask

  task automatic t_one_pass;
    readout(24'h000010, 16'h0001, 1'b0);
    $display("test one_pass finished");
  endtask

  // index wraps past the top of the preloaded words
  task automatic t_wrap_passes;
    readout(24'h0101F8, 16'h0003, 1'b1);
    $display("test wrap_passes finished");
  endtask

  task automatic t_zero_count;
    readout(24'h000004, 16'h0000, 1'b0);
    $display("test zero_count finished");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_addr = 8'h00;
    mem_wr_data = 24'h000000;
    req_valid = 1'b0;
    req_addr = 24'h000000;
    req_passes = 16'h0000;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    cmp(28'(req_ready), 28'h1, "ready after reset");
    preload();
    t_one_pass();
    t_wrap_passes();
    t_zero_count();
    close_out();
  end

  initial begin
    #(5 * 80000);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
